// [verilog/irq_csr_pkg.sv]
/*
 this file holds the shared constants and carrier types of the interrupt
 control and status register block.
 it assumes a 16-bit register bus with word indices as addresses.
*/
`default_nettype none
package irq_csr_pkg;
   // register word addresses
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CORE = 4'h1;
   localparam logic [3:0] ADDR_CTL_ONE = 4'h2;
   localparam logic [3:0] ADDR_CTL_TWO = 4'h3;
   localparam logic [3:0] ADDR_FLAGS = 4'h4;
   localparam logic [3:0] ADDR_ENABLE = 4'h5;
   localparam logic [3:0] ADDR_PRIO_LO = 4'h6;
   localparam logic [3:0] ADDR_PRIO_HI = 4'h7;
   localparam logic [3:0] ADDR_PRIO_X = 4'h8;
   // field positions
   localparam int STATUS_IPL_LSB = 5;
   localparam int CORE_IPL_MSB_POS = 3;
   localparam int NEST_DIS_POS = 15;
   localparam int ALT_TABLE_POS = 15;
   localparam int HOLD_OFF_POS = 14;
   // trap status positions in control word one
   localparam int DIV0_POS = 6;
   localparam int DMA_TRAP_POS = 5;
   localparam int MATH_TRAP_POS = 4;
   localparam int ADDR_TRAP_POS = 3;
   localparam int STACK_TRAP_POS = 2;
   localparam int OSC_TRAP_POS = 1;
   localparam logic [15:0] CTL_ONE_MASK = 16'h807e;
   localparam logic [15:0] CTL_TWO_WMASK = 16'h8007;
   localparam logic [15:0] FLAGS_MASK = 16'h7fff;
   localparam int NUM_SOURCES = 15;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [2:0] LEVEL_BLOCK = 3'h7;
   // trap event bundle from the core
   typedef struct packed {
      logic div_zero;
      logic dma_fault;
      logic math;
      logic address;
      logic stack;
      logic osc_fail;
   } trap_events_t;
   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage
`default_nettype wire

// [verilog/interrupt_control_status_regs.sv]
/*
 this file holds the interrupt control and status register block: priority
 level, nesting disable, trap status, vector table select, edge polarity of
 three external inputs, fifteen request flags and the request decision.
 it assumes trap and source events are one-clock pulses on the same clock,
 external inputs are asynchronous pins, and the bus master never waits.
*/
`timescale 1ns/1ns
`default_nettype none
module interrupt_control_status_regs #(
   parameter int NSRC = irq_csr_pkg::NUM_SOURCES
) (
   input wire logic clock, // system clock, 125 MHz
   input wire logic sys_rst, // asynchronous reset, active high
   input wire logic clk_en, // freezes all state while low
   input wire irq_csr_pkg::bus_req_t bus_req, // register bus request
   output logic [15:0] bus_rdata, // read data, cycle after read
   input wire irq_csr_pkg::trap_events_t trap_events, // trap pulses from core
   input wire logic trap_taken, // core enters a trap, level to 15
   input wire logic hold_off_active, // hold-off instruction running
   input wire logic [2:0] ext_pin, // external interrupt pins 0..2
   input wire logic [NSRC-1:0] src_pulse, // peripheral request pulses
   output logic [3:0] cpu_level, // current four-bit priority level
   output logic user_irq_blocked, // user interrupts masked
   output logic alt_table, // alternate vector table in use
   output logic irq_request, // pending user interrupt
   output logic [3:0] irq_source // winning source index
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [2:0] ipl_low_reg;
   logic ipl_msb_reg;
   logic nesting_disable_reg;
   logic [5:0] trap_flags_reg;
   logic alt_table_reg;
   logic [2:0] edge_pol_reg;
   logic [NSRC-1:0] flags_reg;
   logic [NSRC-1:0] enable_reg;
   logic [3*NSRC-1:0] prio_reg;
   logic [15:0] rdata_reg;
   logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
   logic hold_off_reg;

   ////////////////////////////////////////////////////////////////////////
   // write decode
   wire logic wr_status = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_STATUS;
   wire logic wr_core = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_CORE;
   wire logic wr_one = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_CTL_ONE;
   wire logic wr_two = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_CTL_TWO;
   wire logic wr_flags = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_FLAGS;
   wire logic wr_enable = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_ENABLE;
   wire logic wr_prio_lo = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_PRIO_LO;
   wire logic wr_prio_hi = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_PRIO_HI;
   wire logic wr_prio_x = bus_req.wr && bus_req.addr == irq_csr_pkg::ADDR_PRIO_X;
   wire logic [2:0] wr_ipl = bus_req.wdata[irq_csr_pkg::STATUS_IPL_LSB +: 3];
   wire logic status_write_ok = wr_status && !nesting_disable_reg;

   ////////////////////////////////////////////////////////////////////////
   // trap events in bit order 6..1
   wire logic [5:0] trap_set = {trap_events.div_zero, trap_events.dma_fault,
      trap_events.math, trap_events.address, trap_events.stack,
      trap_events.osc_fail};
   wire logic [5:0] trap_wr = bus_req.wdata[irq_csr_pkg::DIV0_POS:irq_csr_pkg::OSC_TRAP_POS];
   // set wins over software clear
   wire logic [5:0] trap_next = trap_set | (wr_one ? trap_wr : trap_flags_reg);

   ////////////////////////////////////////////////////////////////////////
   // external edge detect after two-stage sync
   wire logic [2:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
   wire logic [2:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
   wire logic [2:0] ext_edge = (edge_pol_reg & pin_fall) | (~edge_pol_reg & pin_rise);

   // external 0 feeds flag bit 0 alongside its peripheral pulse
   wire logic [NSRC-1:0] flag_set = src_pulse | {{(NSRC-1){1'b0}}, ext_edge[0]};
   wire logic [NSRC-1:0] flag_wr = bus_req.wdata[NSRC-1:0];
   wire logic [NSRC-1:0] flags_next = flag_set | (wr_flags ? flag_wr : flags_reg);

   ////////////////////////////////////////////////////////////////////////
   // priority level formation
   assign cpu_level = {ipl_msb_reg, ipl_low_reg};
   assign user_irq_blocked = ipl_msb_reg || ipl_low_reg == irq_csr_pkg::LEVEL_BLOCK;
   assign alt_table = alt_table_reg;

   // highest-priority enabled pending source, lowest index wins ties
   function automatic logic [7:0] pick_source(input logic [NSRC-1:0] act,
                                              input logic [3*NSRC-1:0] pr);
      logic [3:0] best_idx;
      logic [2:0] best_pr;
      logic found;
      best_idx = 4'h0;
      best_pr = 3'h0;
      found = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (act[i] && (!found || pr[3*i +: 3] >= best_pr)) begin
            best_idx = 4'(i);
            best_pr = pr[3*i +: 3];
            found = 1'b1;
         end
      end
      return {found, best_idx, best_pr};
   endfunction

   wire logic [7:0] pick = pick_source(flags_reg & enable_reg, prio_reg);
   wire logic pick_found = pick[7];
   wire logic [2:0] pick_prio = pick[2:0];
   // level 0 sources are disabled by their priority
   assign irq_request = pick_found && !ipl_msb_reg &&
      {1'b0, pick_prio} > cpu_level;
   assign irq_source = pick[6:3];

   ////////////////////////////////////////////////////////////////////////
   // read mux
   logic [15:0] read_word;
   always_comb begin
      read_word = irq_csr_pkg::RESET_WORD;
      unique case (bus_req.addr)
         irq_csr_pkg::ADDR_STATUS: read_word[irq_csr_pkg::STATUS_IPL_LSB +: 3] = ipl_low_reg;
         irq_csr_pkg::ADDR_CORE: read_word[irq_csr_pkg::CORE_IPL_MSB_POS] = ipl_msb_reg;
         irq_csr_pkg::ADDR_CTL_ONE: begin
            read_word[irq_csr_pkg::NEST_DIS_POS] = nesting_disable_reg;
            read_word[irq_csr_pkg::DIV0_POS:irq_csr_pkg::OSC_TRAP_POS] = trap_flags_reg;
         end
         irq_csr_pkg::ADDR_CTL_TWO: begin
            read_word[irq_csr_pkg::ALT_TABLE_POS] = alt_table_reg;
            read_word[irq_csr_pkg::HOLD_OFF_POS] = hold_off_reg;
            read_word[2:0] = edge_pol_reg;
         end
         irq_csr_pkg::ADDR_FLAGS: read_word[NSRC-1:0] = flags_reg;
         irq_csr_pkg::ADDR_ENABLE: read_word[NSRC-1:0] = enable_reg;
         irq_csr_pkg::ADDR_PRIO_LO: read_word = prio_reg[15:0];
         irq_csr_pkg::ADDR_PRIO_HI: read_word = prio_reg[31:16];
         irq_csr_pkg::ADDR_PRIO_X: read_word[3*NSRC-33:0] = prio_reg[3*NSRC-1:32];
         default: read_word = irq_csr_pkg::RESET_WORD;
      endcase
   end
   assign bus_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // priority level field and top bit
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ipl_low_reg <= 3'h0;
         ipl_msb_reg <= 1'b0;
      end else if (clk_en) begin
         if (trap_taken) begin
            ipl_msb_reg <= 1'b1;
            ipl_low_reg <= irq_csr_pkg::LEVEL_BLOCK;
         end else if (status_write_ok) begin
            ipl_low_reg <= wr_ipl;
         end
         // software may only clear the top bit
         if (!trap_taken && wr_core && !bus_req.wdata[irq_csr_pkg::CORE_IPL_MSB_POS]) begin
            ipl_msb_reg <= 1'b0;
         end
      end
   end

   // control words and trap status
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         nesting_disable_reg <= 1'b0;
         trap_flags_reg <= 6'h00;
         alt_table_reg <= 1'b0;
         edge_pol_reg <= 3'h0;
      end else if (clk_en) begin
         trap_flags_reg <= trap_next;
         if (wr_one) begin
            nesting_disable_reg <= bus_req.wdata[irq_csr_pkg::NEST_DIS_POS];
         end
         if (wr_two) begin
            alt_table_reg <= bus_req.wdata[irq_csr_pkg::ALT_TABLE_POS];
            edge_pol_reg <= bus_req.wdata[2:0];
         end
      end
   end

   // flags, enables, priorities
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flags_reg <= '0;
         enable_reg <= '0;
         prio_reg <= '0;
      end else if (clk_en) begin
         flags_reg <= flags_next;
         if (wr_enable) enable_reg <= bus_req.wdata[NSRC-1:0];
         if (wr_prio_lo) prio_reg[15:0] <= bus_req.wdata;
         if (wr_prio_hi) prio_reg[31:16] <= bus_req.wdata;
         if (wr_prio_x) prio_reg[3*NSRC-1:32] <= bus_req.wdata[3*NSRC-33:0];
      end
   end

   // pin synchronisers, hold-off sample, read data
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_s3_reg <= 3'h0;
         hold_off_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else if (clk_en) begin
         pin_s1_reg <= ext_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         hold_off_reg <= hold_off_active;
         rdata_reg <= bus_req.rd ? read_word : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_ipl_locked: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && nesting_disable_reg && !trap_taken |=> $stable(ipl_low_reg))
      else $error("priority field changed while nesting disabled");
   a_msb_no_set: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && !trap_taken && !ipl_msb_reg |=> !ipl_msb_reg)
      else $error("top priority bit set without trap");
   a_block_level: assert property (@(posedge clock) disable iff (sys_rst)
      user_irq_blocked |-> !irq_request)
      else $error("request raised while blocked");
   a_div_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.div_zero |=> trap_flags_reg[5])
      else $error("divide trap flag not set");
   a_osc_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.osc_fail |=> trap_flags_reg[0])
      else $error("oscillator trap flag not set");
   a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && src_pulse[1] |=> flags_reg[1] [*1] ##0 1)
      else $error("source flag lost");
   a_ext_edge: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && ext_edge[0] |=> flags_reg[0])
      else $error("external edge not flagged");
   a_read_timing: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && bus_req.rd && bus_req.addr == irq_csr_pkg::ADDR_FLAGS
      |=> bus_rdata[15] == 1'b0)
      else $error("flag word top bit not zero");
   a_level_form: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_taken |=> cpu_level == 4'hf)
      else $error("trap did not raise level to 15");

   // accepted status write lands in the field
   a_ipl_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && status_write_ok && !trap_taken |=> ipl_low_reg == $past(wr_ipl))
      else $error("priority field write lost");
   // software clear of the top bit
   a_top_clear: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_core && !bus_req.wdata[irq_csr_pkg::CORE_IPL_MSB_POS] && !trap_taken
      |=> !ipl_msb_reg)
      else $error("top priority bit not cleared");
   // top bit reads as level above seven
   a_msb_reads: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && bus_req.rd && bus_req.addr == irq_csr_pkg::ADDR_CORE
      |=> bus_rdata[irq_csr_pkg::CORE_IPL_MSB_POS] == ($past(cpu_level) > 4'h7))
      else $error("top bit read does not match level");
   // nesting disable follows software
   a_nest_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_one |=> nesting_disable_reg == $past(bus_req.wdata[irq_csr_pkg::NEST_DIS_POS]))
      else $error("nesting disable write lost");

   // dma fault trap flag
   a_dma_flag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.dma_fault |=> trap_flags_reg[4])
      else $error("dma trap flag not set");
   // math trap flag
   a_math_flag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.math |=> trap_flags_reg[3])
      else $error("math trap flag not set");
   // address trap flag
   a_addr_flag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.address |=> trap_flags_reg[2])
      else $error("address trap flag not set");
   // stack trap flag
   a_stack_flag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && trap_events.stack |=> trap_flags_reg[1])
      else $error("stack trap flag not set");
   // unused bits of control word one read zero
   a_ctl_one_zero: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && bus_req.rd && bus_req.addr == irq_csr_pkg::ADDR_CTL_ONE
      |=> bus_rdata[14:7] == 8'h00 && !bus_rdata[0])
      else $error("unused control bits not zero");

   // table select follows software
   a_alt_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_two |=> alt_table == $past(bus_req.wdata[irq_csr_pkg::ALT_TABLE_POS]))
      else $error("table select write lost");
   // hold-off status tracks its input
   a_hold_show: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en |=> hold_off_reg == $past(hold_off_active))
      else $error("hold-off status lags");
   // every source pulse lands in its flag
   a_src_flag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && (|src_pulse) |=> (flags_reg & $past(src_pulse)) == $past(src_pulse))
      else $error("source pulse not flagged");
   // winner is flagged and enabled
   a_irq_source: assert property (@(posedge clock) disable iff (sys_rst)
      irq_request |-> flags_reg[irq_source] && enable_reg[irq_source])
      else $error("request from idle source");

   // read data stand one cycle only
   a_read_idle: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && !bus_req.rd |=> bus_rdata == 16'h0000)
      else $error("read data outside read cycle");
   // low enable freezes state
   a_frozen: assert property (@(posedge clock) disable iff (sys_rst)
      !clk_en |=> $stable(flags_reg) && $stable(ipl_low_reg) && $stable(bus_rdata))
      else $error("state moved while frozen");
   // unmapped addresses read zero
   a_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && bus_req.rd && bus_req.addr > irq_csr_pkg::ADDR_PRIO_X |=> bus_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // priority word write lands
   a_prio_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_prio_lo |=> prio_reg[15:0] == $past(bus_req.wdata))
      else $error("priority write lost");
   // enable word write lands
   a_enable_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_enable |=> enable_reg == $past(bus_req.wdata[NSRC-1:0]))
      else $error("enable write lost");
   // software trap write without events
   a_trap_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_one && trap_set == 6'h00 |=> trap_flags_reg == $past(trap_wr))
      else $error("trap status write lost");
   // software flag write without events
   a_flag_write: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wr_flags && flag_set == '0 |=> flags_reg == $past(flag_wr))
      else $error("flag word write lost");

endmodule
`default_nettype wire

// [bench/irq_far_side.sv]
/*
 far side model: trap pulses from the core, request pulses from the
 peripherals, the three external pins and the hold-off level.
 assumes the bench calls one of its tasks at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_far_side (
   input wire logic clock, // system clock
   output var irq_csr_pkg::trap_events_t trap_events, // trap pulses
   output var logic trap_taken, // trap entry pulse
   output var logic hold_off_active, // hold-off level
   output var logic [14:0] src_pulse, // peripheral pulses
   output var logic [2:0] ext_pin // external pins
);
   // quiet at time zero
   initial begin
      trap_events = '0;
      trap_taken = 1'b0;
      hold_off_active = 1'b0;
      src_pulse = 15'h0000;
      ext_pin = 3'h0;
   end
   ////////////////////////////////////////////////////////////
   // one-cycle event pulse, then quiet again
   task automatic fire(input logic [5:0] t, input logic tk, input logic [14:0] s);
      @(posedge clock);
      trap_events <= t;
      trap_taken <= tk;
      src_pulse <= s;
      @(posedge clock);
      trap_events <= '0;
      trap_taken <= 1'b0;
      src_pulse <= 15'h0000;
   endtask
   // pin and hold-off levels, held until changed
   task automatic levels(input logic [2:0] p, input logic h);
      @(posedge clock);
      ext_pin <= p;
      hold_off_active <= h;
   endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
/*
 self-checking bench of the interrupt register block with a register model.
 assumes the far side model drives all event inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clock;
   logic sys_rst;
   logic clk_en;
   irq_csr_pkg::bus_req_t bus_req;
   logic [15:0] bus_rdata;
   irq_csr_pkg::trap_events_t trap_events;
   logic trap_taken;
   logic hold_off_active;
   logic [2:0] ext_pin;
   logic [14:0] src_pulse;
   logic [3:0] cpu_level;
   logic [3:0] irq_source;
   logic user_irq_blocked;
   logic alt_table;
   logic irq_request;
   int fail_count = 0;
   int checks_done = 0;
   logic [2:0] m_ipl = 3'h0;
   logic m_top = 1'b0;
   logic m_hold = 1'b0;
   logic [15:0] m_c1 = 16'h0000;
   logic [15:0] m_c2 = 16'h0000;
   logic [15:0] m_flags = 16'h0000;
   logic [15:0] m_en = 16'h0000;
   logic [44:0] m_prio = '0;
   logic [15:0] rnd = 16'h0027;
   // clock and instances
   initial clock = 1'b0;
   always #4 clock = ~clock;
   interrupt_control_status_regs #(.NSRC(15)) i_dut (.clock(clock), .sys_rst(sys_rst),
      .clk_en(clk_en), .bus_req(bus_req), .bus_rdata(bus_rdata), .trap_events(trap_events),
      .trap_taken(trap_taken), .hold_off_active(hold_off_active), .ext_pin(ext_pin),
      .src_pulse(src_pulse), .cpu_level(cpu_level), .user_irq_blocked(user_irq_blocked),
      .alt_table(alt_table), .irq_request(irq_request), .irq_source(irq_source));
   irq_far_side i_far (.clock(clock), .trap_events(trap_events), .trap_taken(trap_taken),
      .hold_off_active(hold_off_active), .src_pulse(src_pulse), .ext_pin(ext_pin));
   ////////////////////////////////////////////////////////////
   // helpers: random source, compares, model view
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t output %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] exp_word(input logic [3:0] a);
      case (a)
         irq_csr_pkg::ADDR_STATUS: return {8'h00, m_ipl, 5'h00};
         irq_csr_pkg::ADDR_CORE: return {12'h000, m_top, 3'h0};
         irq_csr_pkg::ADDR_CTL_ONE: return m_c1;
         irq_csr_pkg::ADDR_CTL_TWO: return m_c2 | {1'b0, m_hold, 14'h0000};
         irq_csr_pkg::ADDR_FLAGS: return m_flags;
         irq_csr_pkg::ADDR_ENABLE: return m_en;
         irq_csr_pkg::ADDR_PRIO_LO: return m_prio[15:0];
         irq_csr_pkg::ADDR_PRIO_HI: return m_prio[31:16];
         irq_csr_pkg::ADDR_PRIO_X: return {3'h0, m_prio[44:32]};
         default: return 16'h0000;
      endcase
   endfunction
   // bus cycles; the model follows each write at its edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req <= '0;
      if (a == irq_csr_pkg::ADDR_STATUS && !m_c1[15]) m_ipl = d[7:5];
      if (a == irq_csr_pkg::ADDR_CORE && !d[3]) m_top = 1'b0;
      if (a == irq_csr_pkg::ADDR_CTL_ONE) m_c1 = d & irq_csr_pkg::CTL_ONE_MASK;
      if (a == irq_csr_pkg::ADDR_CTL_TWO) m_c2 = d & irq_csr_pkg::CTL_TWO_WMASK;
      if (a == irq_csr_pkg::ADDR_FLAGS) m_flags = d & irq_csr_pkg::FLAGS_MASK;
      if (a == irq_csr_pkg::ADDR_ENABLE) m_en = d & 16'h7fff;
      if (a == irq_csr_pkg::ADDR_PRIO_LO) m_prio[15:0] = d;
      if (a == irq_csr_pkg::ADDR_PRIO_HI) m_prio[31:16] = d;
      if (a == irq_csr_pkg::ADDR_PRIO_X) m_prio[44:32] = d[12:0];
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1;
      cmp_word(bus_rdata, exp_word(a));
   endtask
   // events from the far side
   task automatic ev(input logic [5:0] t, input logic tk, input logic [14:0] s);
      i_far.fire(t, tk, s);
      m_flags = m_flags | {1'b0, s};
      m_c1 = m_c1 | {9'h000, t, 1'b0};
      if (tk) m_top = 1'b1;
      if (tk) m_ipl = 3'h7;
      #1;
   endtask
   task automatic lv(input logic [2:0] p, input logic h);
      if ((p[0] && !ext_pin[0] && !m_c2[0]) || (!p[0] && ext_pin[0] && m_c2[0]))
         m_flags[0] = 1'b1;
      m_hold = h;
      i_far.levels(p, h);
      repeat (6) @(posedge clock);
      #1;
   endtask
   // outputs against the model
   task automatic chk_out;
      logic [2:0] best;
      logic [3:0] win;
      best = 3'h0;
      win = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if (m_flags[i] && m_en[i] && {1'b0, m_prio[3*i +: 3]} > {m_top, m_ipl}
            && m_prio[3*i +: 3] > best) begin
            best = m_prio[3*i +: 3];
            win = i[3:0];
         end
      end
      cmp_out(cpu_level, {m_top, m_ipl});
      cmp_out({3'h0, user_irq_blocked}, {3'h0, m_ipl == 3'h7 || m_top});
      cmp_out({3'h0, alt_table}, {3'h0, m_c2[15]});
      cmp_out({3'h0, irq_request}, {3'h0, best != 3'h0 && !m_top});
      if (best != 3'h0 && !m_top) cmp_out(irq_source, win);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      $display("ERROR %0t watchdog expired", $time);
      summarize;
   end
   // main sequence
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      bus_req = '0;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk_out;
      wr(4'h9, 16'hffff);
      for (int a = 0; a < 10; a++) rd(a[3:0]);
      wr(irq_csr_pkg::ADDR_STATUS, 16'hffff);
      rd(irq_csr_pkg::ADDR_STATUS);
      chk_out;
      @(posedge clock);
      #1;
      cmp_word(bus_rdata, 16'h0000);
      wr(irq_csr_pkg::ADDR_STATUS, 16'h00a0);
      wr(irq_csr_pkg::ADDR_CORE, 16'hffff);
      rd(irq_csr_pkg::ADDR_CORE);
      chk_out;
      ev(6'h00, 1'b1, 15'h0000);
      rd(irq_csr_pkg::ADDR_CORE);
      chk_out;
      wr(irq_csr_pkg::ADDR_CORE, 16'h0000);
      chk_out;
      wr(irq_csr_pkg::ADDR_CTL_ONE, 16'hffff);
      rd(irq_csr_pkg::ADDR_CTL_ONE);
      wr(irq_csr_pkg::ADDR_STATUS, 16'h0040);
      rd(irq_csr_pkg::ADDR_STATUS);
      wr(irq_csr_pkg::ADDR_CTL_ONE, 16'h0000);
      for (int k = 0; k < 6; k++) begin
         ev(6'h01 << k, 1'b0, 15'h0000);
         rd(irq_csr_pkg::ADDR_CTL_ONE);
      end
      wr(irq_csr_pkg::ADDR_CTL_TWO, 16'hffff);
      chk_out;
      lv(3'h0, 1'b1);
      rd(irq_csr_pkg::ADDR_CTL_TWO);
      lv(3'h0, 1'b0);
      wr(irq_csr_pkg::ADDR_CTL_TWO, 16'h0000);
      lv(3'h7, 1'b0);
      rd(irq_csr_pkg::ADDR_FLAGS);
      wr(irq_csr_pkg::ADDR_FLAGS, 16'h0000);
      lv(3'h0, 1'b0);
      rd(irq_csr_pkg::ADDR_FLAGS);
      wr(irq_csr_pkg::ADDR_CTL_TWO, 16'h0007);
      lv(3'h7, 1'b0);
      rd(irq_csr_pkg::ADDR_FLAGS);
      lv(3'h0, 1'b0);
      rd(irq_csr_pkg::ADDR_FLAGS);
      wr(irq_csr_pkg::ADDR_CTL_TWO, 16'h0000);
      for (int n = 0; n < 40; n++) begin
         rnd = lfsr(rnd);
         ev(6'h00, 1'b0, rnd[14:0]);
         for (int a = 5; a < 9; a++) begin
            rnd = lfsr(rnd);
            wr(a[3:0], rnd);
         end
         rnd = lfsr(rnd);
         wr(irq_csr_pkg::ADDR_STATUS, rnd);
         rd(irq_csr_pkg::ADDR_FLAGS);
         rd(irq_csr_pkg::ADDR_PRIO_X);
         chk_out;
         rnd = lfsr(rnd);
         wr(irq_csr_pkg::ADDR_FLAGS, rnd);
      end
      // a write while frozen must not land
      @(posedge clock);
      clk_en <= 1'b0;
      bus_req <= '{addr: irq_csr_pkg::ADDR_STATUS, wdata: {8'h00, ~m_ipl, 5'h00}, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req <= '0;
      clk_en <= 1'b1;
      rd(irq_csr_pkg::ADDR_STATUS);
      summarize;
   end
endmodule
`default_nettype wire
